// File: hw/pcsb_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// small synchronous memory, registered read data
module pcsb_mem #(
  parameter int AW = 6,
  parameter int DW = 32
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1]; // no reset: software configures

  // write port
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// File: hw/pcsb_pkg.sv
package pcsb_pkg;

  // ==========================================================
  // register offsets (byte addresses inside one feature page)
  localparam logic [11:0] SEL_OFF = 12'h100;
  localparam logic [11:0] WIN_OFF = 12'h220;
  localparam logic [11:0] PRI_OFF = 12'h400;
  localparam logic [11:0] MAP_OFF = 12'h600;

  // ==========================================================
  // selector field positions
  localparam int SEL_IDX_LSB = 0;
  localparam int SEL_IDX_W = 16;
  localparam int SEL_INT_BIT = 16;
  localparam int SEL_RIS_LSB = 24;
  localparam int SEL_RIS_W = 4;

  // ==========================================================
  // window width and priority field positions
  localparam int WIN_FRAC_LSB = 0;
  localparam int WIN_INT_LSB = 8;
  localparam int WIN_W = 24;
  localparam int PRI_INT_LSB = 0;
  localparam int PRI_DS_LSB = 16;
  localparam int PRI_FLD_W = 16;

  // ==========================================================
  // reset values
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [23:0] WIN_HW_DEFAULT = 24'h00_0100;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // ==========================================================
  // error codes reported to the error status register
  typedef enum logic [3:0] {
    PCSB_ERR_NONE = 4'h0,
    PCSB_ERR_UNEXP_INTERNAL = 4'h1,
    PCSB_ERR_INT_RANGE = 4'h2
  } pcsb_err_e;

  // one register bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pcsb_req_s;

  // error report towards the error status register
  typedef struct packed {
    logic valid;
    logic secure;
    pcsb_err_e code;
  } pcsb_err_s;

endpackage

// File: hw/pcsb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Window read-only when not writable capability
// - Writable window: per-partition independent width
// - Window absent without bandwidth partitioning: zero
// - Window: int bits 23:8, frac 7:0
// - Separate secure and nonsecure window registers
// - Accesses indexed by instance and partition
// - Narrowing needs internal bit one, else zero
// - Bits 27:24 instance index when supported
// - Internal bit zero without narrowing
// - Internal bit picks request or internal ID
// - Map access with internal set: error
// - Window or priority access, internal clear: range error
// - Errored writes leave settings unchanged
// - Selector bits 15:0 hold partition index
// - Separate secure and nonsecure selectors
// - Priority absent without priority partitioning
// - Priority sets internal and downstream priority
// - Priority: downstream 31:16, internal 15:0
module pcsb_top #(
  parameter bit BW_CAP = 1'b1, // bandwidth_partition_cap
  parameter bit WR_CAP = 1'b1, // window_writable_cap
  parameter bit PRI_CAP = 1'b1, // priority_partition_cap
  parameter bit NRW_CAP = 1'b1, // id_narrowing_cap
  parameter bit RIS_CAP = 1'b1, // instance_select_cap plus extension
  parameter int PW = 4, // implemented partition index bits
  parameter int RW = 1, // implemented instance index bits
  parameter int DSW = 8, // implemented downstream priority bits
  parameter int IPW = 8 // implemented internal priority bits
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pcsb_pkg::pcsb_req_s req,
  output logic rvalid,
  output logic [31:0] rdata,
  output var pcsb_pkg::pcsb_err_s err,
  output logic [PW-1:0] cur_part_s,
  output logic [PW-1:0] cur_part_ns
);

  localparam int AW = 1 + RW + PW; // security, instance, partition

  // ==========================================================
  // selector decode helpers
  function automatic logic [31:0] sel_mask();
    logic [31:0] m;
    m = 32'h0000_0000;
    m[pcsb_pkg::SEL_IDX_LSB +: pcsb_pkg::SEL_IDX_W] = 16'hffff;
    if (NRW_CAP) begin
      m[pcsb_pkg::SEL_INT_BIT] = 1'b1;
    end
    if (RIS_CAP) begin
      m[pcsb_pkg::SEL_RIS_LSB +: pcsb_pkg::SEL_RIS_W] = 4'hf;
    end
    return m;
  endfunction

  // memory index from a selector value and security state
  function automatic logic [AW-1:0] cfg_index(input logic [31:0] sel,
                                             input logic sec);
    logic [RW-1:0] resource_instance_index;
    resource_instance_index = RIS_CAP ? sel[pcsb_pkg::SEL_RIS_LSB +: RW] : '0;
    return {sec, resource_instance_index, sel[pcsb_pkg::SEL_IDX_LSB +: PW]};
  endfunction

  // ==========================================================
  // selectors, one per security state
  logic [31:0] sel_s_r;
  logic [31:0] sel_ns_r;
  logic [31:0] cur_sel; // selector of the requesting state
  logic sel_hit, win_hit, pri_hit, map_hit;
  logic intl;
  logic bad_int, bad_map;
  logic [AW-1:0] idx;

  always_comb begin
    cur_sel = req.secure ? sel_s_r : sel_ns_r;
    sel_hit = 1'b0;
    win_hit = 1'b0;
    pri_hit = 1'b0;
    map_hit = 1'b0;
    // address decode
    if (req.addr == pcsb_pkg::SEL_OFF) begin
      sel_hit = 1'b1;
    end else if (req.addr == pcsb_pkg::WIN_OFF && BW_CAP) begin
      win_hit = 1'b1;
    end else if (req.addr == pcsb_pkg::PRI_OFF && PRI_CAP) begin
      pri_hit = 1'b1;
    end else if (req.addr == pcsb_pkg::MAP_OFF && NRW_CAP) begin
      map_hit = 1'b1;
    end
    intl = cur_sel[pcsb_pkg::SEL_INT_BIT];
    // internal bit checks only when narrowing exists
    bad_map = NRW_CAP && req.valid && map_hit && intl;
    bad_int = NRW_CAP && req.valid && (win_hit || pri_hit)
              && !intl;
    idx = cfg_index(cur_sel, req.secure);
  end

  // selector write; masks reserved bits to zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_s_r <= pcsb_pkg::SEL_RST;
      sel_ns_r <= pcsb_pkg::SEL_RST;
    end else if (req.valid && req.write && sel_hit) begin
      if (req.secure) begin
        sel_s_r <= req.wdata & sel_mask();
      end else begin
        sel_ns_r <= req.wdata & sel_mask();
      end
    end
  end

  // ==========================================================
  // window width storage; written only when writable, no error
  logic win_we, pri_we;
  logic [31:0] win_q, pri_q;
  logic [31:0] win_wd, pri_wd;

  always_comb begin
    win_we = WR_CAP && req.valid && req.write && win_hit
             && !bad_int;
    pri_we = req.valid && req.write && pri_hit && !bad_int;
    win_wd = {8'h00, req.wdata[pcsb_pkg::WIN_FRAC_LSB +:
                                pcsb_pkg::WIN_W]};
    pri_wd = 32'h0000_0000;
    pri_wd[pcsb_pkg::PRI_DS_LSB +: DSW] =
      req.wdata[pcsb_pkg::PRI_DS_LSB +: DSW];
    pri_wd[pcsb_pkg::PRI_INT_LSB +: IPW] =
      req.wdata[pcsb_pkg::PRI_INT_LSB +: IPW];
  end

  // per-partition windows; selector write already seen next cycle
  pcsb_mem #(.AW(AW), .DW(32)) u_win (
    .mclk(mclk),
    .we(win_we),
    .waddr(idx),
    .wdata(win_wd),
    .raddr(idx),
    .rdata(win_q)
  );

  pcsb_mem #(.AW(AW), .DW(32)) u_pri (
    .mclk(mclk),
    .we(pri_we),
    .waddr(idx),
    .wdata(pri_wd),
    .raddr(idx),
    .rdata(pri_q)
  );

  // valid bits so unwritten entries read a defined value
  logic [(1<<AW)-1:0] win_set_r;
  logic [(1<<AW)-1:0] pri_set_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      win_set_r <= '0;
      pri_set_r <= '0;
    end else begin
      if (win_we) begin
        win_set_r[idx] <= 1'b1;
      end
      if (pri_we) begin
        pri_set_r[idx] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read return, two cycles after the request
  typedef enum {PCSB_RD_NONE, PCSB_RD_SEL, PCSB_RD_WIN, PCSB_RD_PRI,
                PCSB_RD_ZERO} pcsb_rd_e;
  pcsb_rd_e rd_kind_r;
  logic rd_pend_r;
  logic win_ok_r, pri_ok_r;
  logic [31:0] sel_cap_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_kind_r <= PCSB_RD_NONE;
      rd_pend_r <= 1'b0;
      win_ok_r <= 1'b0;
      pri_ok_r <= 1'b0;
      sel_cap_r <= 32'h0000_0000;
    end else begin
      rd_pend_r <= req.valid && !req.write;
      win_ok_r <= win_set_r[idx];
      pri_ok_r <= pri_set_r[idx];
      sel_cap_r <= cur_sel;
      if (!(req.valid && !req.write)) begin
        rd_kind_r <= PCSB_RD_NONE;
      end else if (sel_hit) begin
        rd_kind_r <= PCSB_RD_SEL;
      end else if (win_hit && !bad_int) begin
        rd_kind_r <= PCSB_RD_WIN;
      end else if (pri_hit && !bad_int) begin
        rd_kind_r <= PCSB_RD_PRI;
      end else begin
        rd_kind_r <= PCSB_RD_ZERO; // unmapped, absent, errored, map
      end
    end
  end

  // output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= pcsb_pkg::CFG_RST;
    end else begin
      rvalid <= rd_pend_r;
      case (rd_kind_r)
        PCSB_RD_SEL: rdata <= sel_cap_r;
        PCSB_RD_WIN: begin
          // hardware width unless software wrote this entry
          if (WR_CAP && win_ok_r) begin
            rdata <= win_q;
          end else begin
            rdata <= {8'h00, pcsb_pkg::WIN_HW_DEFAULT};
          end
        end
        PCSB_RD_PRI: rdata <= pri_ok_r ? pri_q : pcsb_pkg::CFG_RST;
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  // error report, one cycle pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      err <= '0;
    end else begin
      err.valid <= bad_map || bad_int;
      err.secure <= req.secure;
      if (bad_map) begin
        err.code <= pcsb_pkg::PCSB_ERR_UNEXP_INTERNAL;
      end else if (bad_int) begin
        err.code <= pcsb_pkg::PCSB_ERR_INT_RANGE;
      end else begin
        err.code <= pcsb_pkg::PCSB_ERR_NONE;
      end
    end
  end

  // current partition selection exported
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur_part_s <= '0;
      cur_part_ns <= '0;
    end else begin
      cur_part_s <= sel_s_r[PW-1:0];
      cur_part_ns <= sel_ns_r[PW-1:0];
    end
  end

  // ==========================================================
  // checks
  // neither selector ever stores a reserved bit
  a_sel_reserved: assert property (
    @(posedge mclk) disable iff (rst)
    ((sel_s_r | sel_ns_r) & ~sel_mask()) == 32'h0)
    else $error("selector reserved bit set");
  // a read-only window always answers the hardware width
  a_win_ro: assert property (
    @(posedge mclk) disable iff (rst)
    rvalid && $past(rd_kind_r) == PCSB_RD_WIN && !WR_CAP
    |-> rdata == {8'h00, pcsb_pkg::WIN_HW_DEFAULT})
    else $error("read-only window not hardware width");
  // an errored write leaves the written-entry marks alone
  a_err_nowr: assert property (
    @(posedge mclk) disable iff (rst)
    bad_int && req.write |=> $stable(win_set_r) && $stable(pri_set_r))
    else $error("errored access wrote settings");
  a_err_code: assert property (
    @(posedge mclk) disable iff (rst)
    bad_int && !bad_map |=> err.valid &&
    err.code == pcsb_pkg::PCSB_ERR_INT_RANGE)
    else $error("range error not reported");
  a_map_err: assert property (
    @(posedge mclk) disable iff (rst)
    bad_map |=> err.code == pcsb_pkg::PCSB_ERR_UNEXP_INTERNAL)
    else $error("map error not reported");
  // read answer lands exactly two edges after the request
  a_rd_lat: assert property (
    @(posedge mclk) disable iff (rst)
    req.valid && !req.write |-> ##2 rvalid)
    else $error("read answer late");
  a_win_rsvd: assert property (
    @(posedge mclk) disable iff (rst)
    rvalid && $past(rd_kind_r) == PCSB_RD_WIN |-> rdata[31:24] == 8'h0)
    else $error("window reserved bits nonzero");
  // only a build without bandwidth partitioning reaches this one
  a_absent_zero: assert property (
    @(posedge mclk) disable iff (rst)
    req.valid && !req.write && req.addr == pcsb_pkg::WIN_OFF && !BW_CAP
    |-> ##2 rdata == 32'h0)
    else $error("absent window not zero");
  // main scenarios
  c_sel_wr: cover property (@(posedge mclk) req.valid && req.write
    && sel_hit);
  c_win_wr: cover property (@(posedge mclk) win_we);
  c_range_err: cover property (@(posedge mclk) bad_int);
  c_map_err: cover property (@(posedge mclk) bad_map);

endmodule
`default_nettype wire

// File: tb/partition_config_select_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module partition_config_select_bank_bench;
  // ==========================================================
  // clock, reset, request and observed outputs
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pcsb_pkg::pcsb_req_s req = '0;
  logic rv1, rv2, rv3;
  logic [31:0] rd1, rd2, rd3;
  pcsb_pkg::pcsb_err_s er1, er2, er3;
  logic [3:0] cps, cpn;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'h0b327881;
  // reference copies of selectors, windows, priorities
  logic [31:0] sel_m [2];
  logic [23:0] win_m [64];
  logic [31:0] pri_m [64];
  // expectations launched with the request, then piped
  logic [31:0] x1, x2, a1, a2, b1, b2;
  logic [31:0] x3, c1, c2; // build without bandwidth partitioning
  logic [5:0] xe, ee;
  logic q1 = 1'b0;
  logic q2 = 1'b0;
  logic e1 = 1'b0;
  always #20 mclk = ~mclk;

  // full build and two stripped builds share one request stream
  pcsb_top u_pcsb_top (.mclk(mclk), .rst(rst), .req(req), .rvalid(rv1),
    .rdata(rd1), .err(er1), .cur_part_s(cps), .cur_part_ns(cpn));
  pcsb_top #(.WR_CAP(1'b0), .PRI_CAP(1'b0), .NRW_CAP(1'b0),
    .RIS_CAP(1'b0)) u_pcsb_top_min (.mclk(mclk), .rst(rst), .req(req),
    .rvalid(rv2), .rdata(rd2), .err(er2), .cur_part_s(), .cur_part_ns());
  // no bandwidth partitioning: window location reads as zero
  pcsb_top #(.BW_CAP(1'b0), .WR_CAP(1'b0), .PRI_CAP(1'b0),
    .NRW_CAP(1'b0), .RIS_CAP(1'b0)) u_pcsb_top_nobw (.mclk(mclk),
    .rst(rst), .req(req), .rvalid(rv3), .rdata(rd3), .err(er3),
    .cur_part_s(), .cur_part_ns());

  // ==========================================================
  // compare and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // reference state back to its reset values
  task automatic mreset();
    sel_m[0] = pcsb_pkg::SEL_RST;
    sel_m[1] = pcsb_pkg::SEL_RST;
    for (int i = 0; i < 64; i++) begin
      win_m[i] = pcsb_pkg::WIN_HW_DEFAULT;
      pri_m[i] = pcsb_pkg::CFG_RST;
    end
  endtask

  // ==========================================================
  // one request per cycle; prediction made from prior state
  task automatic op(input logic w, input logic s, input logic [11:0] a,
    input logic [31:0] d);
    logic [31:0] sl;
    logic [5:0] ix;
    logic ok;
    @(posedge mclk);
    #1;
    sl = sel_m[s];
    ix = {s, sl[24], sl[3:0]};
    ok = sl[16];
    req = '{1'b1, w, s, a, d};
    x1 = '0;
    x2 = '0;
    xe = {1'b0, s, pcsb_pkg::PCSB_ERR_NONE};
    if (a == pcsb_pkg::SEL_OFF) begin
      x1 = sl;
      x2 = {16'h0, sl[15:0]};
      if (w) sel_m[s] = d;
    end else if (a == pcsb_pkg::WIN_OFF || a == pcsb_pkg::PRI_OFF) begin
      // clear internal bit: range error, write dropped, read zero
      if (!ok) xe = {1'b1, s, pcsb_pkg::PCSB_ERR_INT_RANGE};
      if (a == pcsb_pkg::WIN_OFF) x2 = {8'h0, pcsb_pkg::WIN_HW_DEFAULT};
      if (ok && a == pcsb_pkg::WIN_OFF) begin
        x1 = {8'h0, win_m[ix]};
        if (w) win_m[ix] = d[23:0];
      end else if (ok) begin
        x1 = pri_m[ix];
        if (w) pri_m[ix] = {8'h0, d[23:16], 8'h0, d[7:0]};
      end
    end else if (a == pcsb_pkg::MAP_OFF && ok) begin
      xe = {1'b1, s, pcsb_pkg::PCSB_ERR_UNEXP_INTERNAL};
    end
    // absent window behaves as reserved zero, rest as stripped build
    x3 = (a == pcsb_pkg::WIN_OFF) ? 32'h0 : x2;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      req.valid = 1'b0;
    end
  endtask

  // ==========================================================
  // pipe expectations to the cycle the answer stands in
  always @(posedge mclk) begin
    q1 <= req.valid && !req.write && !rst;
    q2 <= q1;
    a1 <= x1;
    a2 <= a1;
    b1 <= x2;
    b2 <= b1;
    c1 <= x3;
    c2 <= c1;
    e1 <= req.valid && xe[5] && !rst;
    ee <= xe;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      test_done();
    end
  end
  // outputs are settled by the falling edge
  always @(negedge mclk) begin
    if (!rst) begin
      chk(32'(rv1), 32'(q2));
      chk(32'(rv2), 32'(q2));
      chk(32'(rv3), 32'(q2));
      if (q2) begin
        chk(rd1, a2);
        chk(rd2, b2);
        chk(rd3, c2);
      end
      chk(32'(er1.valid), 32'(e1));
      chk(32'(er2.valid), 32'h0);
      chk(32'(er3.valid), 32'h0);
      if (e1) chk(32'(er1), 32'(ee));
    end
  end

  // ==========================================================
  // corner cases first, then a random mix
  initial begin
    logic [31:0] r, d;
    logic [11:0] ad;
    mreset();
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    op(1'b0, 1'b1, pcsb_pkg::WIN_OFF, 32'h0);
    op(1'b0, 1'b1, pcsb_pkg::MAP_OFF, 32'h0);
    op(1'b1, 1'b1, pcsb_pkg::SEL_OFF, 32'h0001_0003);
    op(1'b1, 1'b1, pcsb_pkg::WIN_OFF, 32'hff12_3456);
    op(1'b0, 1'b1, pcsb_pkg::WIN_OFF, 32'h0);
    op(1'b1, 1'b0, pcsb_pkg::SEL_OFF, 32'h0001_0003);
    op(1'b0, 1'b0, pcsb_pkg::WIN_OFF, 32'h0);
    op(1'b0, 1'b1, pcsb_pkg::MAP_OFF, 32'h0);
    op(1'b1, 1'b1, pcsb_pkg::SEL_OFF, 32'h0101_0003);
    op(1'b0, 1'b1, pcsb_pkg::WIN_OFF, 32'h0);
    for (int i = 0; i < 600; i++) begin
      r = $random(seed);
      d = $random(seed);
      case (r[2:0] % 5)
        0: ad = pcsb_pkg::SEL_OFF;
        1: ad = pcsb_pkg::WIN_OFF;
        2: ad = pcsb_pkg::PRI_OFF;
        3: ad = pcsb_pkg::MAP_OFF;
        default: ad = 12'h004; // unmapped offset
      endcase
      // selector data kept to implemented fields, internal mostly set
      if (ad == pcsb_pkg::SEL_OFF) d = (d & 32'h0100_ffff) |
        {15'h0, r[5] | r[6], 16'h0};
      op(r[3], r[4], ad, d);
      if (r[9:7] == 3'h0) idle(1);
    end
    idle(4);
    chk(32'(cps), 32'(sel_m[1][3:0]));
    chk(32'(cpn), 32'(sel_m[0][3:0]));
    // second reset in mid-run
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    mreset();
    op(1'b0, 1'b1, pcsb_pkg::SEL_OFF, 32'h0);
    op(1'b0, 1'b0, pcsb_pkg::PRI_OFF, 32'h0);
    idle(4);
    test_done();
  end
endmodule
`default_nettype wire
